// >>> hdl/stc_pkg.sv
// Purpose: Shared constants and types for the sixteen-bit timer/counter
// Assumes: Byte-wide register port with a three-bit word address
// Notes: Offsets, field positions, reset values and timing counts live here
package stc_pkg;

  // Register word addresses
  localparam logic [2:0] STC_ADDR_COUNT_LOW = 3'h0;
  localparam logic [2:0] STC_ADDR_COUNT_HIGH = 3'h1;
  localparam logic [2:0] STC_ADDR_CONTROL = 3'h2;
  localparam logic [2:0] STC_ADDR_FLAG = 3'h3;
  localparam logic [2:0] STC_ADDR_ENABLE = 3'h4;
  localparam logic [2:0] STC_ADDR_CMP_LOW = 3'h5;
  localparam logic [2:0] STC_ADDR_CMP_HIGH = 3'h6;
  localparam logic [2:0] STC_ADDR_CMP_MODE = 3'h7;

  // Control register field positions
  localparam int STC_BIT_RUN = 0;
  localparam int STC_BIT_SRC = 1;
  localparam int STC_BIT_SYNC_DIS = 2;
  localparam int STC_BIT_OSC_EN = 3;
  localparam int STC_BIT_PS_LO = 4;
  localparam int STC_BIT_WIDE = 7;

  // Reset values and implemented-bit masks
  localparam logic [7:0] STC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] STC_CONTROL_MASK = 8'hBF;
  localparam logic [7:0] STC_CMP_MODE_MASK = 8'h1F;

  // Flag, enable and compare-mode fields
  localparam int STC_BIT_OVF = 0;
  localparam int STC_BIT_ADC_EN = 4;
  localparam logic [3:0] STC_MODE_SPECIAL = 4'hB;

  // Count limits
  localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] STC_COUNT_ZERO = 16'h0000;

  // Timing: system clock and instruction clock ratio
  localparam int STC_CLK_MHZ = 40;
  localparam int STC_INSTR_DIV = 4;

  // Control register layout
  typedef struct packed {
    logic wide_access_enable;
    logic reserved;
    logic [1:0] input_prescale_select;
    logic low_power_osc_enable;
    logic sync_disable;
    logic clock_source_select;
    logic counter_run;
  } stc_ctrl_t;

  // Software request carried as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } stc_req_t;

  // Operating mode decoded from source and sync bits
  typedef enum logic [1:0] {
    STC_TIMER,
    STC_SYNC_COUNTER,
    STC_ASYNC_COUNTER
  } stc_mode_t;

endpackage

// >>> hdl/stc_timer.sv
// Purpose: Sixteen-bit timer/counter with prescaler, overflow flag and compare trigger
// Assumes: All pin inputs synchronous to i_clk; i_clk is the system clock, i_osc_clk a counted source
// Notes: Count bytes are not reset; they hold whatever they had until written
//
// Notes on behaviour
// RULE1: External input synchronised unless sync disabled
// RULE2: Internal source ignores the sync bit
// RULE3: Source bit picks pin or instruction clock
// RULE4: Run bit counts or holds
// RULE5: Timer, sync and async counter modes
// RULE6: One step per tick or rising edge
// RULE7: Oscillator pins become inputs reading zero
// RULE8: Oscillator enable bit starts oscillator, survives sleep
// RULE9: Software waits for oscillator start-up
// RULE10: Count wraps at FFFF, sets overflow flag
// RULE11: Interrupt only while enable bit set
// RULE12: Mode 1011 match clears count, starts conversion
// RULE13: Trigger clear never sets overflow flag
// RULE14: Trigger clear only in synchronous modes
// RULE15: Software write beats trigger clear
// RULE16: Compare pair acts as count period
// RULE17: Wide mode low read latches high byte
// RULE18: Wide mode high write buffered, low write commits
// RULE19: Low write clears prescaler, high does not
// RULE20: Count bytes not reset; control resets zero
// RULE21: Prescale codes divide by 1, 2, 4, 8
// RULE22: Narrow mode bytes accessed directly
// RULE23: Two-flop synchroniser before edge detection
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module stc_timer
  import stc_pkg::*;
#(
  parameter int INSTR_DIV = STC_INSTR_DIV,
  parameter int PRESCALE_W = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Count inputs
  input wire logic i_ext_count_pin,
  input wire logic i_osc_clk,
  input wire logic i_sleep,
  // Oscillator pins shared with the port
  input wire logic [1:0] i_port_direction_reg,
  input wire logic [1:0] i_port_out,
  input wire logic [1:0] i_pin_in,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe,
  output logic [1:0] o_port_read,
  // Status and events
  output logic o_osc_run,
  output logic o_irq,
  output logic o_adc_start
);

  // Prescale code to terminal count, shared by tick and clear logic
  function automatic logic [PRESCALE_W-1:0] ps_limit(input logic [1:0] code);
    logic [PRESCALE_W-1:0] lim;
    lim = '0;
    case (code)
      2'h0: lim = PRESCALE_W'(0);
      2'h1: lim = PRESCALE_W'(1);
      2'h2: lim = PRESCALE_W'(3);
      default: lim = PRESCALE_W'(7);
    endcase
    return lim;
  endfunction

  // Reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Register storage
  stc_ctrl_t ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [7:0] hbuf_ff;
  logic [7:0] nxt_hbuf;
  logic [15:0] cmp_ff;
  logic [7:0] cmp_mode_ff;
  logic ovf_flag_ff;
  logic nxt_ovf_flag;
  logic ovf_en_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic adc_start_ff;
  logic osc_run_ff;
  logic [1:0] pin_out_ff;
  logic [1:0] pin_oe_ff;
  logic [1:0] port_read_ff;

  // Request bundle
  stc_req_t req;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // Address decode
  wire wr_low = req.wr && (req.addr == STC_ADDR_COUNT_LOW);
  wire wr_high = req.wr && (req.addr == STC_ADDR_COUNT_HIGH);
  wire wr_ctrl = req.wr && (req.addr == STC_ADDR_CONTROL);
  wire wr_flag = req.wr && (req.addr == STC_ADDR_FLAG);
  wire wr_en = req.wr && (req.addr == STC_ADDR_ENABLE);
  wire wr_cmp_lo = req.wr && (req.addr == STC_ADDR_CMP_LOW);
  wire wr_cmp_hi = req.wr && (req.addr == STC_ADDR_CMP_HIGH);
  wire wr_cmp_mode = req.wr && (req.addr == STC_ADDR_CMP_MODE);
  wire rd_low = req.rd && (req.addr == STC_ADDR_COUNT_LOW);
  wire wide = ctrl_ff.wide_access_enable;

  // Mode decode; the sync bit only matters with the external source
  // Synchronised counting costs two cycles of latency but rejects glitches
  stc_mode_t mode;
  // RULE5: mode selection
  // RULE2: sync ignored internally
  assign mode = !ctrl_ff.clock_source_select ? STC_TIMER :
                ctrl_ff.sync_disable ? STC_ASYNC_COUNTER : STC_SYNC_COUNTER;

  // Instruction clock enable, one pulse every INSTR_DIV cycles
  // Free-running from reset, so a start waits at most INSTR_DIV cycles for a tick
  logic [3:0] div_ff;
  wire div_wrap = (div_ff == 4'(INSTR_DIV - 1));
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_wrap ? 4'h0 : div_ff + 4'h1;
    end
  end

  // External source: oscillator output when enabled, else the count pin
  wire ext_src = ctrl_ff.low_power_osc_enable ? i_osc_clk : i_ext_count_pin;

  // RULE23: synchroniser stage feeding only the second flop
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_sync_ff;
  logic ext_prev_raw_ff;
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_sync_ff <= 1'b0;
      ext_prev_raw_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_src;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_sync_ff <= ext_sync_ff;
      ext_prev_raw_ff <= ext_src;
    end
  end

  // Rising edges; the raw path saves two cycles of latency but sees glitches
  wire edge_sync = ext_sync_ff && !ext_prev_sync_ff;
  wire edge_raw = ext_src && !ext_prev_raw_ff;

  // RULE1: pick synchronised or raw edge
  // RULE3: pin edge or instruction tick
  // RULE6: one tick per edge or cycle
  logic src_tick;
  always_comb begin
    src_tick = 1'b0;
    case (mode)
      STC_TIMER: src_tick = div_wrap;
      STC_SYNC_COUNTER: src_tick = edge_sync;
      STC_ASYNC_COUNTER: src_tick = edge_raw;
      default: src_tick = 1'b0;
    endcase
  end

  // Apart from the clear on a low-byte write, the prescaler only moves while running, so a halt keeps its phase
  // RULE21: prescaler divides by 1, 2, 4 or 8
  logic [PRESCALE_W-1:0] ps_ff;
  wire [PRESCALE_W-1:0] ps_lim = ps_limit(ctrl_ff.input_prescale_select);
  wire ps_done = (ps_ff >= ps_lim);
  // RULE4: halted counter takes no steps
  wire step = ctrl_ff.counter_run && src_tick && ps_done;
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ps_ff <= '0;
    end else if (wr_low) begin
      // RULE19: low-byte write clears prescaler
      ps_ff <= '0;
    end else if (ctrl_ff.counter_run && src_tick) begin
      ps_ff <= ps_done ? '0 : ps_ff + PRESCALE_W'(1);
    end
  end

  // The trigger repeats each cycle the count sits on the compare value
  // Async mode never clears: the raw edge could race the clear
  // RULE12: special event on compare match
  // RULE16: compare pair sets the period
  // RULE14: no trigger clear in async mode
  wire special_mode = (cmp_mode_ff[3:0] == STC_MODE_SPECIAL);
  wire trig = special_mode && (count_ff == cmp_ff) && ctrl_ff.counter_run;
  wire trig_clear = trig && (mode != STC_ASYNC_COUNTER);

  // Count next value; writes first, then trigger clear, then step
  wire sw_write = wr_low || (wr_high && !wide);
  wire wrap = step && (count_ff == STC_COUNT_MAX) && !sw_write && !trig_clear;
  always_comb begin
    nxt_count = count_ff;
    if (wr_low && wide) begin
      // RULE18: commit buffered high with low
      nxt_count = {hbuf_ff, req.wdata};
    end else if (wr_low) begin
      // RULE22: direct low-byte write
      nxt_count = {count_ff[15:8], req.wdata};
    end else if (wr_high && !wide) begin
      // RULE22: direct high-byte write
      nxt_count = {req.wdata, count_ff[7:0]};
    end else if (trig_clear) begin
      // RULE15: clear only when no write
      nxt_count = STC_COUNT_ZERO;
    end else if (step) begin
      // RULE10: wraps from FFFF to zero
      nxt_count = count_ff + 16'h0001;
    end
  end

  // Power-on leaves the count unknown; software loads it before use
  // RULE20: count bytes carry no reset
  always_ff @(posedge i_clk) begin
    count_ff <= nxt_count;
  end

  // High byte buffer for wide access
  // Latching on the low read spares software a rollover check between bytes
  always_comb begin
    nxt_hbuf = hbuf_ff;
    if (rd_low && wide) begin
      // RULE17: low read latches high byte
      nxt_hbuf = count_ff[15:8];
    end else if (wr_high && wide) begin
      // RULE18: high write loads buffer only
      nxt_hbuf = req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      hbuf_ff <= 8'h00;
    end else begin
      hbuf_ff <= nxt_hbuf;
    end
  end

  // Software may also set the flag by writing one, which helps test a handler
  // RULE10: wrap sets overflow flag, set beats clear
  // RULE13: trigger clear is not a wrap
  always_comb begin
    nxt_ovf_flag = ovf_flag_ff;
    if (wr_flag) begin
      nxt_ovf_flag = req.wdata[STC_BIT_OVF];
    end
    if (wrap) begin
      nxt_ovf_flag = 1'b1;
    end
  end

  // Control, flag, enable and compare registers
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff <= STC_CONTROL_RESET;
      ovf_flag_ff <= 1'b0;
      ovf_en_ff <= 1'b0;
      cmp_ff <= 16'h0000;
      cmp_mode_ff <= 8'h00;
    end else begin
      ovf_flag_ff <= nxt_ovf_flag;
      if (wr_ctrl) begin
        // RULE20: unimplemented bit stays zero
        ctrl_ff <= req.wdata & STC_CONTROL_MASK;
      end
      if (wr_en) begin
        ovf_en_ff <= req.wdata[STC_BIT_OVF];
      end
      if (wr_cmp_lo) begin
        cmp_ff[7:0] <= req.wdata;
      end
      if (wr_cmp_hi) begin
        cmp_ff[15:8] <= req.wdata;
      end
      if (wr_cmp_mode) begin
        cmp_mode_ff <= req.wdata & STC_CMP_MODE_MASK;
      end
    end
  end

  // Read mux; unmapped bits read zero
  // Data holds between reads, so a slow sampler needs no extra strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req.rd) begin
      case (req.addr)
        STC_ADDR_COUNT_LOW: nxt_rdata = count_ff[7:0];
        STC_ADDR_COUNT_HIGH: nxt_rdata = wide ? hbuf_ff : count_ff[15:8];
        STC_ADDR_CONTROL: nxt_rdata = ctrl_ff;
        STC_ADDR_FLAG: nxt_rdata = {7'h00, ovf_flag_ff};
        STC_ADDR_ENABLE: nxt_rdata = {7'h00, ovf_en_ff};
        STC_ADDR_CMP_LOW: nxt_rdata = cmp_ff[7:0];
        STC_ADDR_CMP_HIGH: nxt_rdata = cmp_ff[15:8];
        STC_ADDR_CMP_MODE: nxt_rdata = cmp_mode_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Pin control: oscillator forces inputs; direction bit 1 means input
  wire osc_en = ctrl_ff.low_power_osc_enable;
  // RULE7: pins input, reads zero
  // One slice per shared pin, so a third pin widens the loop bound and the two-bit pin vectors
  logic [1:0] nxt_pin_oe;
  logic [1:0] nxt_port_read;
  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign nxt_pin_oe[p] = osc_en ? 1'b0 : ~i_port_direction_reg[p];
    assign nxt_port_read[p] = osc_en ? 1'b0 : i_pin_in[p];
  end

  // Output flops; the interrupt lags the flag by one cycle
  // Every output leaves a flop, so pin timing never depends on decode depth
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      adc_start_ff <= 1'b0;
      osc_run_ff <= 1'b0;
      pin_out_ff <= 2'h0;
      pin_oe_ff <= 2'h0;
      port_read_ff <= 2'h0;
    end else begin
      rdata_ff <= nxt_rdata;
      // RULE11: flag gated by enable
      irq_ff <= ovf_flag_ff && ovf_en_ff;
      // RULE12: conversion start when converter enabled
      adc_start_ff <= trig && cmp_mode_ff[STC_BIT_ADC_EN];
      // RULE8: oscillator ignores sleep
      osc_run_ff <= osc_en;
      pin_out_ff <= i_port_out;
      pin_oe_ff <= nxt_pin_oe;
      port_read_ff <= nxt_port_read;
    end
  end

  // Sleep does not touch this block: the oscillator and counter keep going
  wire unused_sleep = i_sleep;

  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;
  assign o_adc_start = adc_start_ff;
  assign o_osc_run = osc_run_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe = pin_oe_ff;
  assign o_port_read = port_read_ff;

endmodule

`default_nettype wire

// >>> testbench/stc_timer_sva.sv
// Purpose: Port-level checks for the timer/counter
// Assumes: One clock; first request well after reset release
// Notes: Shadows of control and compare mode follow software writes
`timescale 1ns/100ps
`default_nettype none

module stc_timer_sva
  import stc_pkg::*;
#(
  parameter int INSTR_DIV = STC_INSTR_DIV,
  parameter int PRESCALE_W = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Count inputs
  input wire logic i_ext_count_pin,
  input wire logic i_osc_clk,
  input wire logic i_sleep,
  // Oscillator pins
  input wire logic [1:0] i_port_direction_reg,
  input wire logic [1:0] i_port_out,
  input wire logic [1:0] i_pin_in,
  input wire logic [1:0] o_pin_out,
  input wire logic [1:0] o_pin_oe,
  input wire logic [1:0] o_port_read,
  // Status
  input wire logic o_osc_run,
  input wire logic o_irq,
  input wire logic o_adc_start
);
  logic [2:0] age_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mode_ff;
  wire logic live = (age_ff == 3'h7);

  // Skip the internal reset tail, whose outputs are all held low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      age_ff <= 3'h0;
      ctrl_ff <= STC_CONTROL_RESET;
      mode_ff <= 8'h00;
    end else begin
      age_ff <= live ? age_ff : age_ff + 3'h1;
      if (i_wr && i_addr == STC_ADDR_CONTROL) ctrl_ff <= i_wdata & STC_CONTROL_MASK;
      if (i_wr && i_addr == STC_ADDR_CMP_MODE) mode_ff <= i_wdata & STC_CMP_MODE_MASK;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence ctrl_wr_s;
    live && i_wr && i_addr == STC_ADDR_CONTROL;
  endsequence
  sequence ctrl_rd_s;
    live && i_rd && i_addr == STC_ADDR_CONTROL;
  endsequence

  osc_follow_a: assert property (ctrl_wr_s |-> ##2 o_osc_run == $past(i_wdata[3], 2))
    else $error("oscillator run does not follow enable bit");
  pins_input_a: assert property (o_osc_run |-> o_pin_oe == 2'h0 && o_port_read == 2'h0)
    else $error("oscillator pins not released to input");
  oe_dir_a: assert property (live && !o_osc_run |-> o_pin_oe == ~$past(i_port_direction_reg))
    else $error("pin enable does not follow direction");
  pin_out_a: assert property (live |-> o_pin_out == $past(i_port_out))
    else $error("pin output does not follow port data");
  irq_mask_a: assert property (live && i_wr && i_addr == STC_ADDR_ENABLE && !i_wdata[0] |-> ##2 !o_irq)
    else $error("interrupt seen while masked");
  ctrl_read_a: assert property (ctrl_rd_s |=> o_rdata == ctrl_ff)
    else $error("control read mismatch");
  adc_mode_a: assert property (o_adc_start |-> mode_ff[4] && mode_ff[3:0] == STC_MODE_SPECIAL)
    else $error("conversion start outside trigger mode");
  rdata_hold_a: assert property (live && !i_rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
endmodule

bind stc_timer stc_timer_sva #(.INSTR_DIV(INSTR_DIV), .PRESCALE_W(PRESCALE_W)) chk_u (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_count_pin(i_ext_count_pin),
  .i_osc_clk(i_osc_clk), .i_sleep(i_sleep), .i_port_direction_reg(i_port_direction_reg),
  .i_port_out(i_port_out), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_port_read(o_port_read), .o_osc_run(o_osc_run),
  .o_irq(o_irq), .o_adc_start(o_adc_start));

`default_nettype wire

// >>> testbench/stc_ext_src.sv
// Purpose: External count pin and low-power oscillator seen by the block
// Assumes: Levels change just after a rising clock edge
// Notes: Both sources rest low between bursts
`timescale 1ns/100ps
`default_nettype none

module stc_ext_src (
  // Clock
  input wire logic i_clk,
  // Source levels
  output logic o_ext_pin,
  output logic o_osc_clk
);
  // Idle low, so no edge is seen when the source is switched
  initial begin
    o_ext_pin = 1'b0;
    o_osc_clk = 1'b0;
  end

  task automatic burst(input int n, input bit osc, input int hold);
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge i_clk);
      if (osc) begin
        o_osc_clk <= ~o_osc_clk;
      end else begin
        o_ext_pin <= ~o_ext_pin;
      end
      repeat (hold - 1) @(posedge i_clk);
    end
  endtask
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the timer/counter
// Assumes: Register port master with one-cycle strobes
// Notes: Tick phase runs free, so timed counts allow one step of slack
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import stc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_sleep = 1'b0;
  logic [1:0] i_dir = 2'h2;
  logic [1:0] i_port_out = 2'h1;
  logic [1:0] i_pin_in = 2'h3;
  wire logic ext_pin;
  wire logic osc_clk;
  wire logic [7:0] o_rdata;
  wire logic [1:0] o_port_read;
  wire logic o_osc_run;
  wire logic o_irq;
  wire logic o_adc_start;
  int error_cnt = 0;
  int comparisons = 0;
  logic [7:0] rd_v;
  logic [7:0] held;
  int n;

  // 25 ns clock
  always #12.5 i_clk = ~i_clk;

  stc_timer dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_count_pin(ext_pin),
    .i_osc_clk(osc_clk), .i_sleep(i_sleep), .i_port_direction_reg(i_dir),
    .i_port_out(i_port_out), .i_pin_in(i_pin_in), .o_pin_out(), .o_pin_oe(),
    .o_port_read(o_port_read), .o_osc_run(o_osc_run), .o_irq(o_irq),
    .o_adc_start(o_adc_start));

  stc_ext_src src_u (.i_clk(i_clk), .o_ext_pin(ext_pin), .o_osc_clk(osc_clk));

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  // Range compare; an unknown never lands inside
  task automatic chk_in(input string s, input int lo, input int hi, input logic [7:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("BAD %s expected %0d to %0d seen %h", s, lo, hi, g);
    end
  endtask

  task automatic rdck(input logic [2:0] a, input string s, input logic [7:0] e);
    rd(a);
    chk(s, e, rd_v);
  endtask

  task automatic setc(input logic [7:0] h, input logic [7:0] l);
    wr(STC_ADDR_CONTROL, 8'h00);
    wr(STC_ADDR_COUNT_HIGH, h);
    wr(STC_ADDR_COUNT_LOW, l);
  endtask

  task automatic t_reset();
    rdck(STC_ADDR_CONTROL, "control", 8'h00);
    wr(STC_ADDR_CONTROL, 8'hFE);
    rdck(STC_ADDR_CONTROL, "control", 8'hBE);
  endtask

  task automatic t_prescale();
    for (int c = 0; c < 4; c++) begin
      setc(8'h00, 8'h00);
      wr(STC_ADDR_CONTROL, {2'b00, 2'(c), 4'h5});
      repeat (126) @(posedge i_clk);
      wr(STC_ADDR_CONTROL, 8'h00);
      rd(STC_ADDR_COUNT_LOW);
      chk_in("timer count", (32 >> c) - 1, (32 >> c) + 1, rd_v);
      held = rd_v;
      repeat (20) @(posedge i_clk);
      rdck(STC_ADDR_COUNT_LOW, "halted count", held);
    end
  endtask

  task automatic t_ext();
    setc(8'h00, 8'h00);
    wr(STC_ADDR_CONTROL, 8'h03);
    src_u.burst(5, 1'b0, 3);
    repeat (6) @(posedge i_clk);
    rdck(STC_ADDR_COUNT_LOW, "synced count", 8'h05);
    wr(STC_ADDR_CONTROL, 8'h07);
    src_u.burst(3, 1'b0, 1);
    repeat (6) @(posedge i_clk);
    rdck(STC_ADDR_COUNT_LOW, "raw count", 8'h08);
    wr(STC_ADDR_CONTROL, 8'h0A);
    i_sleep <= 1'b1;
    i_port_out <= 2'h2;
    repeat (40) @(posedge i_clk);
    chk("osc run", 8'h01, {7'h0, o_osc_run});
    chk("port read", 8'h00, {6'h0, o_port_read});
    wr(STC_ADDR_CONTROL, 8'h0B);
    src_u.burst(4, 1'b1, 2);
    repeat (6) @(posedge i_clk);
    rdck(STC_ADDR_COUNT_LOW, "osc count", 8'h0C);
    wr(STC_ADDR_CONTROL, 8'h00);
    i_sleep <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk("port read", 8'h03, {6'h0, o_port_read});
  endtask

  task automatic t_wrap();
    setc(8'hFF, 8'hFE);
    wr(STC_ADDR_CONTROL, 8'h01);
    repeat (20) @(posedge i_clk);
    wr(STC_ADDR_CONTROL, 8'h00);
    rd(STC_ADDR_FLAG);
    chk("flag", 8'h01, {7'h0, rd_v[0]});
    rdck(STC_ADDR_COUNT_HIGH, "wrapped high", 8'h00);
    chk("masked irq", 8'h00, {7'h0, o_irq});
    wr(STC_ADDR_ENABLE, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 chk("irq", 8'h01, {7'h0, o_irq});
    wr(STC_ADDR_ENABLE, 8'h00);
    wr(STC_ADDR_FLAG, 8'h00);
  endtask

  task automatic t_trig();
    setc(8'h00, 8'h00);
    wr(STC_ADDR_CMP_LOW, 8'h10);
    wr(STC_ADDR_CMP_HIGH, 8'h00);
    wr(STC_ADDR_CMP_MODE, 8'h1B);
    wr(STC_ADDR_CONTROL, 8'h01);
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge i_clk);
      #1 if (o_adc_start === 1'b1) n++;
    end
    wr(STC_ADDR_CONTROL, 8'h00);
    chk_in("conversion starts", 2, 3, 8'(n));
    rd(STC_ADDR_COUNT_LOW);
    chk_in("period count", 0, 16, rd_v);
    rd(STC_ADDR_FLAG);
    chk("trigger flag", 8'h00, {7'h0, rd_v[0]});
    wr(STC_ADDR_CMP_MODE, 8'h00);
  endtask

  task automatic t_clr();
    setc(8'h00, 8'h00);
    wr(STC_ADDR_CMP_LOW, 8'h05);
    wr(STC_ADDR_CMP_MODE, 8'h0B);
    wr(STC_ADDR_CONTROL, 8'h03);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= STC_ADDR_COUNT_LOW;
    i_wdata <= 8'h05;
    @(posedge i_clk);
    i_wdata <= 8'h07;
    @(posedge i_clk);
    i_wr <= 1'b0;
    rdck(STC_ADDR_COUNT_LOW, "write over clear", 8'h07);
    wr(STC_ADDR_COUNT_LOW, 8'h05);
    rdck(STC_ADDR_COUNT_LOW, "trigger clear", 8'h00);
    rdck(STC_ADDR_FLAG, "clear flag", 8'h00);
    wr(STC_ADDR_CONTROL, 8'h07);
    wr(STC_ADDR_COUNT_LOW, 8'h05);
    rdck(STC_ADDR_COUNT_LOW, "async no clear", 8'h05);
    wr(STC_ADDR_CMP_MODE, 8'h00);
    wr(STC_ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_psclr();
    setc(8'h00, 8'h00);
    wr(STC_ADDR_CONTROL, 8'h37);
    src_u.burst(7, 1'b0, 1);
    wr(STC_ADDR_COUNT_HIGH, 8'h00);
    src_u.burst(1, 1'b0, 1);
    rdck(STC_ADDR_COUNT_LOW, "high write keeps prescale", 8'h01);
    src_u.burst(7, 1'b0, 1);
    wr(STC_ADDR_COUNT_LOW, 8'h00);
    src_u.burst(1, 1'b0, 1);
    rdck(STC_ADDR_COUNT_LOW, "low write clears prescale", 8'h00);
    wr(STC_ADDR_CONTROL, 8'h00);
  endtask

  task automatic t_wide();
    wr(STC_ADDR_CONTROL, 8'h80);
    wr(STC_ADDR_COUNT_HIGH, 8'h12);
    wr(STC_ADDR_COUNT_LOW, 8'h34);
    wr(STC_ADDR_CONTROL, 8'h80);
    wr(STC_ADDR_COUNT_HIGH, 8'h77);
    wr(STC_ADDR_CONTROL, 8'h00);
    i_dir <= 2'h1;
    rdck(STC_ADDR_COUNT_HIGH, "live high", 8'h12);
    rdck(STC_ADDR_COUNT_LOW, "live low", 8'h34);
    wr(STC_ADDR_CONTROL, 8'h80);
    rdck(STC_ADDR_COUNT_LOW, "wide low", 8'h34);
    rdck(STC_ADDR_COUNT_HIGH, "latched high", 8'h12);
    wr(STC_ADDR_CONTROL, 8'h00);
    wr(STC_ADDR_COUNT_HIGH, 8'h56);
    rdck(STC_ADDR_COUNT_HIGH, "direct high", 8'h56);
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_prescale();
    t_ext();
    t_wrap();
    t_trig();
    t_clr();
    t_psclr();
    t_wide();
    conclude();
  end
endmodule

`default_nettype wire
